// file: design/cal_scale.sv
`include "cal_scale_cfg.svh"
// Summary of operation
// - Factory stage output is factory gain times (input minus factory offset).
// - Factory gain and offset are constants; parameter writes cannot change them.
// - Cleared per-channel factory enable passes the value through uncorrected.
// - User calibration output is user gain times (input minus user offset).
// - User calibration off after reset; active only when its channel flag is set.
// - User calibration offset and gain come from two writable per-channel parameters.
// - Scaling output is scaling gain times (input minus scaling offset).
// - Scaling off after reset; active only when its channel flag is set.
// - Scaling offset and gain come from two writable per-channel parameters.
// - Range status bits are derived from the user-calibrated value.
// - Output presented signed, unsigned with negative values clamped to zero, or sign-magnitude.
module cal_scale (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sample_valid,
	output logic sample_ready,
	input wire logic [2:0] sample_ch,
	input wire logic [15:0] sample_raw,
	output logic value_valid,
	input wire logic value_ready,
	output logic [2:0] value_ch,
	output logic [15:0] value_data,
	output logic [1:0] value_range,
	input wire logic par_req,
	input wire logic par_write,
	input wire logic [15:0] par_index,
	input wire logic [7:0] par_sub,
	input wire logic [31:0] par_wdata,
	output logic par_ack,
	output logic par_err,
	output logic [31:0] par_rdata,
	input wire logic overtemp_pin,
	input wire logic short_pin,
	input wire logic supply_low_pin,
	input wire logic aux_supply_low_pin,
	input wire logic aux_supply_state_pin
);
	localparam int N = `NUM_CH;
	logic scale_en_reg [N], scale_en_next [N];
	logic ucal_en_reg [N], ucal_en_next [N];
	logic fcal_en_reg [N], fcal_en_next [N];
	logic [1:0] pres_reg [N], pres_next [N];
	logic [15:0] scale_ofs_reg [N], scale_ofs_next [N];
	logic [31:0] scale_gain_reg [N], scale_gain_next [N];
	logic [15:0] ucal_ofs_reg [N], ucal_ofs_next [N];
	logic [15:0] ucal_gain_reg [N], ucal_gain_next [N];
	logic [15:0] raw_reg [N], raw_next [N];
	logic [4:0] diag_s1_reg, diag_s2_reg;
	logic par_ack_reg, par_ack_next, par_err_reg, par_err_next;
	logic [31:0] par_rdata_reg, par_rdata_next;
	logic [2:0] acc_ch;
	logic acc_hit;
	logic [15:0] acc_base;

	// Channel decode of the parameter index
	always_comb begin
		acc_base = par_index - `IDX_SETTINGS;
		acc_ch = acc_base[6:4];
		acc_hit = (acc_base[15:7] == 9'h000);
	end

	always_comb begin
		par_ack_next = par_req;
		par_err_next = 1'b0;
		par_rdata_next = 32'h00000000;
		if (par_req && (par_index == `IDX_DIAG)) begin
			par_err_next = par_write;
			case (par_sub)
				`SUB_DIAG_OVERTEMP: par_rdata_next = {31'h0, diag_s2_reg[0]};
				`SUB_DIAG_SHORT: par_rdata_next = {31'h0, diag_s2_reg[1]};
				`SUB_DIAG_SUPPLY_LOW: par_rdata_next = {31'h0, diag_s2_reg[2]};
				`SUB_DIAG_AUX_LOW: par_rdata_next = {31'h0, diag_s2_reg[3]};
				`SUB_DIAG_AUX_STATE: par_rdata_next = {31'h0, diag_s2_reg[4]};
				default: par_err_next = 1'b1;
			endcase
		end else if (par_req && acc_hit && (acc_base[3:0] == 4'h0)) begin
			case (par_sub)
				`SUB_SCALE_EN: par_rdata_next = {31'h0, scale_en_reg[acc_ch]};
				`SUB_PRESENT: par_rdata_next = {30'h0, pres_reg[acc_ch]};
				`SUB_USER_CAL_EN: par_rdata_next = {31'h0, ucal_en_reg[acc_ch]};
				`SUB_FACTORY_EN: par_rdata_next = {31'h0, fcal_en_reg[acc_ch]};
				`SUB_SCALE_OFS: par_rdata_next = {16'h0, scale_ofs_reg[acc_ch]};
				`SUB_SCALE_GAIN: par_rdata_next = scale_gain_reg[acc_ch];
				`SUB_USER_CAL_OFS: par_rdata_next = {16'h0, ucal_ofs_reg[acc_ch]};
				`SUB_USER_CAL_GAIN: par_rdata_next = {16'h0, ucal_gain_reg[acc_ch]};
				default: par_err_next = 1'b1;
			endcase
			if (par_write && (par_sub == `SUB_PRESENT) && (par_wdata[1:0] == 2'h3)) begin
				par_err_next = 1'b1;
			end
		end else if (par_req && acc_hit && (acc_base[3:0] == 4'hE)) begin
			par_err_next = par_write || (par_sub != `SUB_RAW);
			par_rdata_next = {16'h0, raw_reg[acc_ch]};
		end else if (par_req && acc_hit && (acc_base[3:0] == 4'hF)) begin
			// Factory coefficients are readable, never writable
			par_err_next = par_write;
			case (par_sub)
				`SUB_FACTORY_OFS: par_rdata_next = {16'h0, `RST_FACTORY_OFS};
				`SUB_FACTORY_GAIN: par_rdata_next = {16'h0, `RST_FACTORY_GAIN};
				default: par_err_next = 1'b1;
			endcase
		end else if (par_req) begin
			par_err_next = 1'b1;
		end
		if (par_write) begin
			par_rdata_next = 32'h00000000;
		end
	end

	generate
		for (genvar c = 0; c < N; c++) begin : g_regs
			logic wr;
			always_comb begin
				wr = par_req && par_write && acc_hit && (acc_base[3:0] == 4'h0)
					&& (acc_ch == 3'(c));
				scale_en_next[c] = scale_en_reg[c];
				ucal_en_next[c] = ucal_en_reg[c];
				fcal_en_next[c] = fcal_en_reg[c];
				pres_next[c] = pres_reg[c];
				scale_ofs_next[c] = scale_ofs_reg[c];
				scale_gain_next[c] = scale_gain_reg[c];
				ucal_ofs_next[c] = ucal_ofs_reg[c];
				ucal_gain_next[c] = ucal_gain_reg[c];
				raw_next[c] = raw_reg[c];
				if (sample_valid && sample_ready && (sample_ch == 3'(c))) begin
					raw_next[c] = sample_raw;
				end
				if (wr) begin
					case (par_sub)
						`SUB_SCALE_EN: scale_en_next[c] = par_wdata[0];
						`SUB_USER_CAL_EN: ucal_en_next[c] = par_wdata[0];
						`SUB_FACTORY_EN: fcal_en_next[c] = par_wdata[0];
						`SUB_PRESENT: begin
							if (par_wdata[1:0] != 2'h3) begin
								pres_next[c] = par_wdata[1:0];
							end
						end
						`SUB_SCALE_OFS: scale_ofs_next[c] = par_wdata[15:0];
						`SUB_SCALE_GAIN: scale_gain_next[c] = par_wdata;
						`SUB_USER_CAL_OFS: ucal_ofs_next[c] = par_wdata[15:0];
						`SUB_USER_CAL_GAIN: ucal_gain_next[c] = par_wdata[15:0];
						default: ;
					endcase
				end
			end
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					scale_en_reg[c] <= `RST_SCALE_EN;
					ucal_en_reg[c] <= `RST_USER_CAL_EN;
					fcal_en_reg[c] <= `RST_FACTORY_EN;
					pres_reg[c] <= `RST_PRESENT;
					scale_ofs_reg[c] <= `RST_SCALE_OFS;
					scale_gain_reg[c] <= `RST_SCALE_GAIN;
					ucal_ofs_reg[c] <= `RST_USER_CAL_OFS;
					ucal_gain_reg[c] <= `RST_USER_CAL_GAIN;
					raw_reg[c] <= 16'h0000;
				end else begin
					scale_en_reg[c] <= scale_en_next[c];
					ucal_en_reg[c] <= ucal_en_next[c];
					fcal_en_reg[c] <= fcal_en_next[c];
					pres_reg[c] <= pres_next[c];
					scale_ofs_reg[c] <= scale_ofs_next[c];
					scale_gain_reg[c] <= scale_gain_next[c];
					ucal_ofs_reg[c] <= ucal_ofs_next[c];
					ucal_gain_reg[c] <= ucal_gain_next[c];
					raw_reg[c] <= raw_next[c];
				end
			end
		end
	endgenerate

	// Saturate a wide signed value to 16 bits
	function automatic logic [15:0] sat16(input logic signed [63:0] v);
		if (v > 64'sd32767) begin
			sat16 = 16'h7FFF;
		end else if (v < -64'sd32768) begin
			sat16 = 16'h8000;
		end else begin
			sat16 = v[15:0];
		end
	endfunction : sat16

	// Correction datapath, one combinational pass per accepted sample
	logic [15:0] f_out, u_out, s_out, p_out;
	logic [1:0] range_flag;
	logic signed [63:0] f_wide, u_wide, s_wide;
	logic [2:0] ch;
	logic fifo_ready;
	always_comb begin
		ch = sample_ch;
		f_wide = (64'(signed'(`RST_FACTORY_GAIN)) * (64'(signed'(sample_raw))
			- 64'(signed'(`RST_FACTORY_OFS)))) >>> `GAIN16_SHIFT;
		f_out = fcal_en_reg[ch] ? sat16(f_wide) : sample_raw;
		u_wide = (64'(signed'(ucal_gain_reg[ch])) * (64'(signed'(f_out))
			- 64'(signed'(ucal_ofs_reg[ch])))) >>> `GAIN16_SHIFT;
		u_out = ucal_en_reg[ch] ? sat16(u_wide) : f_out;
		// Range status: bit0 at positive limit, bit1 at negative limit
		range_flag = {u_out == 16'h8000, u_out == 16'h7FFF};
		s_wide = (64'(signed'(scale_gain_reg[ch])) * (64'(signed'(u_out))
			- 64'(signed'(scale_ofs_reg[ch])))) >>> `GAIN32_SHIFT;
		s_out = scale_en_reg[ch] ? sat16(s_wide) : u_out;
		case (cal_scale_pkg::presentation_t'(pres_reg[ch]))
			cal_scale_pkg::PRES_SIGNED: p_out = s_out;
			cal_scale_pkg::PRES_UNSIGNED: p_out = s_out[15] ? 16'h0000 : s_out;
			cal_scale_pkg::PRES_ABS_SIGN: begin
				p_out = s_out[15] ? {1'b1, 15'(16'(-s_out))} : s_out;
				if (s_out == 16'h8000) begin
					p_out = 16'hFFFF;
				end
			end
			default: p_out = s_out;
		endcase
	end

	logic fifo_valid;
	logic [20:0] fifo_data;
	logic out_valid_reg, out_valid_next;
	logic [20:0] out_reg, out_next;
	cal_fifo #(.WIDTH(21), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(sample_valid),
		.in_ready(fifo_ready),
		.in_data({range_flag, ch, p_out}),
		.out_valid(fifo_valid),
		.out_ready(!out_valid_reg || value_ready),
		.out_data(fifo_data)
	);
	assign sample_ready = fifo_ready;

	always_comb begin
		out_valid_next = out_valid_reg;
		out_next = out_reg;
		if (!out_valid_reg || value_ready) begin
			out_valid_next = fifo_valid;
			if (fifo_valid) begin
				out_next = fifo_data;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_valid_reg <= 1'b0;
			out_reg <= '0;
			par_ack_reg <= 1'b0;
			par_err_reg <= 1'b0;
			par_rdata_reg <= 32'h00000000;
			diag_s1_reg <= 5'h00;
			diag_s2_reg <= 5'h00;
		end else begin
			out_valid_reg <= out_valid_next;
			out_reg <= out_next;
			par_ack_reg <= par_ack_next;
			par_err_reg <= par_err_next;
			par_rdata_reg <= par_rdata_next;
			diag_s1_reg <= {aux_supply_state_pin, aux_supply_low_pin, supply_low_pin,
				short_pin, overtemp_pin};
			diag_s2_reg <= diag_s1_reg;
		end
	end

	assign value_valid = out_valid_reg;
	assign value_range = out_reg[20:19];
	assign value_ch = out_reg[18:16];
	assign value_data = out_reg[15:0];
	assign par_ack = par_ack_reg;
	assign par_err = par_err_reg;
	assign par_rdata = par_rdata_reg;
endmodule : cal_scale

// file: design/cal_scale_cfg.svh
`ifndef CAL_SCALE_CFG_SVH
`define CAL_SCALE_CFG_SVH
`define NUM_CH 8
`define CH_STRIDE 16'h0010
`define IDX_SETTINGS 16'h0800
`define IDX_RAW 16'h080E
`define IDX_FACTORY 16'h080F
`define IDX_DIAG 16'h0A00
`define SUB_SCALE_EN 8'h01
`define SUB_PRESENT 8'h02
`define SUB_USER_CAL_EN 8'h0A
`define SUB_FACTORY_EN 8'h0B
`define SUB_SCALE_OFS 8'h11
`define SUB_SCALE_GAIN 8'h12
`define SUB_USER_CAL_OFS 8'h17
`define SUB_USER_CAL_GAIN 8'h18
`define SUB_FACTORY_OFS 8'h01
`define SUB_FACTORY_GAIN 8'h02
`define SUB_RAW 8'h01
`define SUB_DIAG_OVERTEMP 8'h01
`define SUB_DIAG_SHORT 8'h02
`define SUB_DIAG_SUPPLY_LOW 8'h03
`define SUB_DIAG_AUX_LOW 8'h04
`define SUB_DIAG_AUX_STATE 8'h05
`define RST_SCALE_EN 1'h0
`define RST_USER_CAL_EN 1'h0
`define RST_FACTORY_EN 1'h1
`define RST_PRESENT 2'h0
`define RST_SCALE_OFS 16'h0000
`define RST_SCALE_GAIN 32'h00010000
`define RST_USER_CAL_OFS 16'h0000
`define RST_USER_CAL_GAIN 16'h4000
`define RST_FACTORY_OFS 16'h0000
`define RST_FACTORY_GAIN 16'h4000
`define GAIN16_SHIFT 14
`define GAIN32_SHIFT 16
`define FIFO_DEPTH 8
`endif

// file: design/cal_scale_pkg.sv
package cal_scale_pkg;
	typedef enum logic [1:0] {
		PRES_SIGNED,
		PRES_UNSIGNED,
		PRES_ABS_SIGN
	} presentation_t;
	typedef enum logic {
		ST_IDLE,
		ST_EMIT
	} pipe_state_t;
endpackage : cal_scale_pkg

// file: design/cal_fifo.sv
module cal_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;
	logic in_ready_reg, in_ready_next;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		wr_next = push ? AW'(wr_reg + 1'b1) : wr_reg;
		rd_next = pop ? AW'(rd_reg + 1'b1) : rd_reg;
		cnt_next = (AW+1)'(cnt_reg + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0));
		in_ready_next = (cnt_next != (AW+1)'(DEPTH));
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			in_ready_reg <= 1'b1;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
			in_ready_reg <= in_ready_next;
		end
	end

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end

	assign in_ready = in_ready_reg;
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem[rd_reg];
endmodule : cal_fifo

// file: sim/cal_scale_chk.sv
module cal_scale_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sample_ready,
	input wire logic value_valid,
	input wire logic value_ready,
	input wire logic [15:0] value_data,
	input wire logic [1:0] value_range,
	input wire logic par_req,
	input wire logic par_write,
	input wire logic [15:0] par_index,
	input wire logic [7:0] par_sub,
	input wire logic [31:0] par_wdata,
	input wire logic par_ack,
	input wire logic par_err,
	input wire logic [31:0] par_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ch_space;
	assign ch_space = par_index[15:7] == 9'h010;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	ack_after_req_a: assert property (par_req |=> par_ack)
		else $error("request without ack");
	ack_has_cause_a: assert property (par_ack |-> $past(par_req))
		else $error("ack without request");
	fixed_ro_a: assert property (par_req && par_write && ch_space && par_index[3:1] == 3'h7
		|=> par_ack && par_err) else $error("write to fixed entry taken");
	diag_ro_a: assert property (par_req && par_write && par_index == 16'h0A00
		|=> par_err) else $error("diagnosis write taken");
	factory_gain_a: assert property (par_req && !par_write && ch_space && par_index[3:0] == 4'hF
		&& par_sub == 8'h02 |=> par_rdata == 32'h00004000 && !par_err)
		else $error("factory gain not unity");
	code_three_a: assert property (par_req && par_write && ch_space && par_index[3:0] == 4'h0
		&& par_sub == 8'h02 && par_wdata == 32'h00000003 |=> par_err)
		else $error("format code three taken");
	word_hold_a: assert property (value_valid && !value_ready
		|=> value_valid && $stable(value_data) && $stable(value_range))
		else $error("output word changed while stalled");
	range_excl_a: assert property (value_valid |-> value_range != 2'h3)
		else $error("both range flags set");
	cover property (par_ack && par_err);
	cover property (value_valid && value_ready);
	cover property (!sample_ready);
endmodule : cal_scale_chk

// file: sim/value_sink.sv
module value_sink (
	input wire logic mclk,
	input wire logic rst,
	input wire logic value_valid,
	input wire logic [15:0] value_data,
	input wire logic [1:0] value_range,
	input wire logic [2:0] value_ch,
	input wire logic stall,
	output logic value_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [20:0] q[$];
	// Ready changes only after an edge
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			value_ready <= 1'b0;
		end else begin
			if (value_valid && value_ready) begin
				q.push_back({value_ch, value_range, value_data});
			end
			value_ready <= !stall;
		end
	end
endmodule : value_sink

// file: sim/cal_scale_tb.sv
module cal_scale_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic sample_valid = 1'b0;
	logic [2:0] sample_ch = 3'h0;
	logic [15:0] sample_raw = 16'h0000;
	logic par_req = 1'b0;
	logic par_write = 1'b0;
	logic [15:0] par_index = 16'h0000;
	logic [7:0] par_sub = 8'h00;
	logic [31:0] par_wdata = 32'h00000000;
	logic [4:0] pins = 5'h0D;
	logic stall = 1'b0;
	logic sample_ready, value_valid, value_ready, par_ack, par_err;
	logic [2:0] value_ch;
	logic [15:0] value_data;
	logic [1:0] value_range;
	logic [31:0] par_rdata, rdv;
	logic erv;
	logic [20:0] w;
	int mismatches = 0;
	int comparisons = 0;
	int n;
	logic [7:0] subs [8] = '{8'h01, 8'h02, 8'h0A, 8'h0B, 8'h11, 8'h12, 8'h17, 8'h18};
	logic [31:0] dflt [8] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h10000, 32'h0, 32'h4000};
	always #4 mclk = ~mclk;
	cal_scale cal_scale_inst (.mclk, .rst, .sample_valid, .sample_ready, .sample_ch, .sample_raw,
		.value_valid, .value_ready, .value_ch, .value_data, .value_range, .par_req, .par_write,
		.par_index, .par_sub, .par_wdata, .par_ack, .par_err, .par_rdata,
		.overtemp_pin(pins[0]), .short_pin(pins[1]), .supply_low_pin(pins[2]),
		.aux_supply_low_pin(pins[3]), .aux_supply_state_pin(pins[4]));
	value_sink value_sink_inst (.mclk, .rst, .value_valid, .value_data, .value_range, .value_ch,
		.stall, .value_ready);
	task results;
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task tmo;
		mismatches++;
		results;
	endtask : tmo
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : chk
	task acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
		@(posedge mclk);
		par_req <= 1'b1;
		par_write <= wr;
		par_index <= idx;
		par_sub <= sub;
		par_wdata <= d;
		@(posedge mclk);
		par_req <= 1'b0;
		#1;
		chk("par_ack", 32'h1, {31'h0, par_ack});
		rdv = par_rdata;
		erv = par_err;
	endtask : acc
	task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d, input logic e);
		acc(1'b1, idx, sub, d);
		chk("par_err", {31'h0, e}, {31'h0, erv});
		chk("par_rdata", 32'h0, rdv);
	endtask : wr
	task rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
		acc(1'b0, idx, sub, 32'h0);
		chk("par_rdata", e, rdv);
		chk("par_err", 32'h0, {31'h0, erv});
	endtask : rd
	task pop(input logic [2:0] ch, input logic [17:0] e);
		n = 0;
		while (value_sink_inst.q.size() == 0 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		if (n == 50) tmo();
		w = value_sink_inst.q.pop_front();
		chk("value", {14'h0, e}, {14'h0, w[17:0]});
		chk("value_ch", {29'h0, ch}, {29'h0, w[20:18]});
	endtask : pop
	task snd(input logic [2:0] ch, input logic [15:0] raw, input logic [17:0] e);
		@(posedge mclk);
		sample_valid <= 1'b1;
		sample_ch <= ch;
		sample_raw <= raw;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (sample_ready !== 1'b1 && n < 50);
		sample_valid <= 1'b0;
		if (n == 50) tmo();
		pop(ch, e);
	endtask : snd
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) rd(16'h0800, subs[i], dflt[i]);
		rd(16'h080F, 8'h02, 32'h4000);
		rd(16'h080F, 8'h01, 32'h0);
		wr(16'h080F, 8'h02, 32'h1234, 1'b1);
		rd(16'h080F, 8'h02, 32'h4000);
		wr(16'h081E, 8'h01, 32'h5, 1'b1);
		wr(16'h0A00, 8'h01, 32'h0, 1'b1);
		for (int i = 1; i < 6; i++) rd(16'h0A00, i[7:0], {31'h0, pins[i-1]});
		wr(16'h0800, 8'h03, 32'h0, 1'b1);
		snd(3'h0, 16'h0064, 18'h00064);
		wr(16'h0810, 8'h0B, 32'h0, 1'b0);
		wr(16'h0810, 8'h17, 32'h10, 1'b0);
		wr(16'h0810, 8'h18, 32'h2000, 1'b0);
		wr(16'h0810, 8'h0A, 32'h1, 1'b0);
		snd(3'h1, 16'h0100, 18'h00078);
		snd(3'h0, 16'h0100, 18'h00100);
		wr(16'h0810, 8'h11, 32'h8, 1'b0);
		wr(16'h0810, 8'h12, 32'h20000, 1'b0);
		wr(16'h0810, 8'h01, 32'h1, 1'b0);
		snd(3'h1, 16'h0100, 18'h000E0);
		wr(16'h0870, 8'h02, 32'h3, 1'b1);
		wr(16'h0870, 8'h02, 32'h1, 1'b0);
		snd(3'h7, 16'hFFFB, 18'h00000);
		wr(16'h0870, 8'h02, 32'h2, 1'b0);
		snd(3'h7, 16'hFFFB, 18'h08005);
		wr(16'h0870, 8'h02, 32'h0, 1'b0);
		snd(3'h7, 16'hFFFB, 18'h0FFFB);
		rd(16'h087E, 8'h01, 32'h0000FFFB);
		@(posedge mclk);
		stall <= 1'b1;
		sample_valid <= 1'b1;
		sample_ch <= 3'h0;
		sample_raw <= 16'h0000;
		n = 0;
		repeat (20) begin
			@(posedge mclk);
			if (sample_ready === 1'b1) begin
				n++;
				sample_raw <= n[15:0];
			end
		end
		sample_valid <= 1'b0;
		stall <= 1'b0;
		chk("accepted", 32'd9, n);
		for (int i = 0; i < 9; i++) pop(3'h0, {2'h0, i[15:0]});
		wr(16'h0800, 8'h18, 32'h7FFF, 1'b0);
		wr(16'h0800, 8'h0A, 32'h1, 1'b0);
		snd(3'h0, 16'h7FFF, 18'h17FFF);
		results;
	end
endmodule : cal_scale_tb
bind cal_scale cal_scale_chk cal_scale_chk_inst (.mclk, .rst, .sample_ready, .value_valid,
	.value_ready, .value_data, .value_range, .par_req, .par_write, .par_index, .par_sub,
	.par_wdata, .par_ack, .par_err, .par_rdata);
